// [bench/tb_turbo_decoder_error_status.sv]
// self-checking bench for the error check and progress register bank.
// assumes the design answers each APB access with pready; core model drives status inputs.
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin mismatches++; \
	$display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb_turbo_decoder_error_status
	import tdes_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic                pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [ADDR_W-1:0]   paddr = '0;
	logic [31:0]         pwdata = '0, prdata, rd;
	logic                pready, pslverr, err, cur_fault = 1'b0, cpu_halt_req = 1'b0;
	logic                decoder_halt, input_fault, hpr, shared_decode_mode, half;
	logic [3:0]          top, sub, mp, c_top = 4'h0, c_sub = 4'h0, c_map = 4'h0;
	logic [4:0]          iter, c_iter = '0;
	logic [6:0]          w, c_waits = '0;
	logic                c_half = 1'b1;
	logic [1:0]          hcfg = 2'h0, block_code_type;
	logic [FRAME_W-1:0]  frame_len;
	logic [SUBF_W-1:0]   subframe_len;
	logic [PROLOG_W-1:0] prolog_len;
	int                  mismatches = 0, cmp_count = 0;

	always #2 pclk = ~pclk;

	tdes_core_model tdes_core_model_i (.pclk(pclk), .presetn(presetn), .decoder_halt(decoder_halt),
		.cmd_top(c_top), .cmd_iter(c_iter), .cmd_subst(c_sub), .cmd_half(c_half), .cmd_waits(c_waits),
		.cmd_map(c_map), .top_state(top), .active_iter(iter), .active_substate(sub), .active_half(half),
		.waits(w), .map_state(mp), .halt_point_reached(hpr));
	tdes_regs tdes_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.top_state(top), .active_iter(iter), .active_substate(sub), .active_half(half),
		.halt_point_reached(hpr), .out_param_read_wait(w[6]), .hard_decision_read_wait(w[5]),
		.extrinsic0_read_wait(w[4]), .apriori_write_wait(w[3]), .sys_parity_write_wait(w[2]),
		.interleaver_load_wait(w[1]), .ctrl_word_load_wait(w[0]), .map_state(mp),
		.cpu_halt_req(cpu_halt_req), .decoder_halt(decoder_halt), .input_fault(input_fault),
		.frame_len(frame_len), .subframe_len(subframe_len), .prolog_len(prolog_len),
		.shared_decode_mode(shared_decode_mode), .block_code_type(block_code_type));

	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// only the watchdog ends a wait for the answer
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		`CHK("pready", 1'b1, pready)
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] ex, input string nm);
		apb(1'b0, a, 32'h0);
		`CHK(nm, ex, rd)
	endtask

	// limits written out independently of the package constants
	function automatic logic [4:0] exp_flt(logic [14:0] f, logic [12:0] s, logic [5:0] p, logic [2:0] m);
		logic [4:0] e;
		e = '0;
		e[4] = s > 13'd5114;
		e[2] = p < 6'd4 || p > 6'd48;
		if (!m[0])
			e[1] = f < 15'd40 || f > 15'd20730;
		else if (m[2:1] == 2'd3)
			e[1] = f < 15'd128 || f > 15'd20480;
		else if (m[2:1] != 2'd0)
			e[1] = f < 15'd256 || f > 15'd20480 || f[7:0] != 8'h0;
		else
			e[1] = 1'b1;
		e[0] = |e[4:1];
		return e;
	endfunction

	task automatic do_case(input logic [14:0] f, input logic [12:0] s, input logic [5:0] p, input logic [2:0] m);
		logic [4:0] e;
		e = exp_flt(f, s, p, m);
		apb(1'b1, OFS_FRAME, {17'h1ffff, f});
		apb(1'b1, OFS_SUBF, {19'h7ffff, s});
		apb(1'b1, OFS_PROLOG, {26'h0, p});
		apb(1'b1, OFS_MODE, {29'h0, m});
		rd_chk(OFS_FRAME, {17'h0, f}, "frame_len");
		rd_chk(OFS_FAULTS, {27'h0, e}, "input_check_faults");
		`CHK("input_fault", e[0], input_fault)
		cur_fault = e[0];
		apb(1'b0, OFS_PROGRESS, 32'h0);
		`CHK("progress fault", e[0], rd[ST_FAULT_BIT])
	endtask

	task automatic prog_chk(input logic [6:0] wt, input logic [3:0] m, input logic halted);
		logic [31:0] e;
		c_waits <= wt;
		c_map <= m;
		c_top <= ~m;
		c_iter <= {1'b1, m};
		c_sub <= wt[3:0];
		c_half <= wt[0];
		repeat (8) @(posedge pclk);
		e = {4'h0, ~m, 3'h0, 1'b1, m, wt[3:0], (hcfg == 2'h0) ? 1'b0 : wt[0],
			(hcfg == 2'h0) ? halted : 1'b0, wt, cur_fault, m >= 4'd1 && m <= 4'd8, 1'b0};
		apb(1'b0, OFS_PROGRESS, 32'h0);
		`CHK("decoder_progress", e, rd)
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		$display("watchdog expired");
		conclude();
	end

	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(OFS_FRAME, 32'h28, "frame reset");
		rd_chk(OFS_SUBF, 32'h0, "subframe reset");
		rd_chk(OFS_PROLOG, 32'h4, "prolog reset");
		rd_chk(OFS_MODE, 32'h2, "mode reset");
		rd_chk(OFS_HALT, 32'h0, "halt reset");
		apb(1'b1, OFS_FAULTS, 32'hffffffff);
		rd_chk(OFS_FAULTS, 32'h0, "faults after write");
		apb(1'b0, 8'h1c, 32'h0);
		`CHK("unmapped err", 1'b1, err)
		`CHK("unmapped data", 32'h0, rd)
		do_case(15'd40, 13'd5114, 6'd4, 3'h0);
		do_case(15'd39, 13'd5115, 6'd48, 3'h0);
		do_case(15'd20730, 13'd0, 6'd3, 3'h0);
		do_case(15'd20731, 13'd0, 6'd49, 3'h0);
		do_case(15'd256, 13'd0, 6'd4, 3'h3);
		do_case(15'd255, 13'd0, 6'd4, 3'h3);
		do_case(15'd20480, 13'd0, 6'd4, 3'h5);
		do_case(15'd20736, 13'd0, 6'd4, 3'h5);
		do_case(15'd384, 13'd0, 6'd4, 3'h3);
		do_case(15'd256, 13'd0, 6'd4, 3'h1);
		do_case(15'd128, 13'd0, 6'd4, 3'h7);
		do_case(15'd127, 13'd0, 6'd4, 3'h7);
		do_case(15'd20481, 13'd0, 6'd4, 3'h7);
		for (int i = 0; i < 7; i++)
			prog_chk(7'(1 << i), 4'h0, 1'b0);
		for (int i = 0; i < 10; i++)
			prog_chk(7'h0, 4'(i), 1'b0);
		apb(1'b1, OFS_PROGRESS, 32'hffffffff);
		prog_chk(7'h55, 4'h9, 1'b0);
		cpu_halt_req <= 1'b1;
		prog_chk(7'h7f, 4'h3, 1'b1);
		`CHK("decoder_halt", 1'b1, decoder_halt)
		cpu_halt_req <= 1'b0;
		prog_chk(7'h2a, 4'h2, 1'b0);
		hcfg = 2'h1;
		apb(1'b1, OFS_HALT, 32'h1);
		cpu_halt_req <= 1'b1;
		prog_chk(7'h11, 4'h1, 1'b0);
		`CHK("halt ignored", 1'b0, decoder_halt)
		hcfg = 2'h2;
		apb(1'b1, OFS_HALT, 32'h2);
		prog_chk(7'h08, 4'h5, 1'b0);
		hcfg = 2'h3;
		apb(1'b1, OFS_HALT, 32'h3);
		prog_chk(7'h21, 4'h7, 1'b0);
		`CHK("halt ignored with select", 1'b0, decoder_halt)
		cpu_halt_req <= 1'b0;
		conclude();
	end
endmodule
`undef CHK
`default_nettype wire

// [bench/tdes_core_model.sv]
// behavioural decoder core feeding the progress inputs of the register bank.
// assumes bench commands change right after a rising pclk edge.
`default_nettype none
module tdes_core_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       decoder_halt,
	input  wire logic [3:0] cmd_top,
	input  wire logic [4:0] cmd_iter,
	input  wire logic [3:0] cmd_subst,
	input  wire logic       cmd_half,
	input  wire logic [6:0] cmd_waits,
	input  wire logic [3:0] cmd_map,
	output logic      [3:0] top_state,
	output logic      [4:0] active_iter,
	output logic      [3:0] active_substate,
	output logic            active_half,
	output logic      [6:0] waits,
	output logic      [3:0] map_state,
	output logic            halt_point_reached
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			top_state <= '0;
			active_iter <= '0;
			active_substate <= '0;
			active_half <= 1'b0;
			waits <= '0;
			map_state <= '0;
			halt_point_reached <= 1'b0;
		end else begin
			top_state <= cmd_top;
			active_iter <= cmd_iter;
			active_substate <= cmd_subst;
			active_half <= cmd_half;
			waits <= cmd_waits;
			map_state <= cmd_map;
			// a real core needs a cycle to reach its halt point after being told to stop
			halt_point_reached <= decoder_halt;
		end
	end
endmodule
`default_nettype wire

// [rtl/tdes_pkg.sv]
// constants for the turbo decoder error and status register bank.
// assumes a single 250 MHz clock and an APB slave with 32-bit data.
// Contract
// - subframe length above 5114 sets error bit 4
// - prolog below 4 or above 48 sets bit 2
// - full mode frame outside 40..20730 sets bit 1
// - shared type 1/2 frame bad range or unaligned
// - shared type 3 frame outside 128..20480 flagged
// - any input fault sets error bit 0
// - reserved bits read zero, writes ignored
// - top-level state shown in status 27-24
// - iteration, substate, half-decoder in status fields
// - bit 11 reserved when ignore and select zero
// - bit 10 high while stopped by debug halt
// - bit 10 reserved when ignore zero, select one
// - bit 9 waits for output parameter read
// - bit 8 waits for hard decision readout
// - bit 7 waits for extrinsic memory 0 readout
// - bit 6 waits for a priori write
// - bit 5 waits for systematic/parity write
// - bit 4 waits for interleaver index load
// - bit 3 waits for control word load
// - status bit 2 shows input fault
// - bit 1 high when engine in states 1..8
// - halt ignore bit overrides any debug halt
`default_nettype none
package tdes_pkg;
	localparam int ADDR_W = 8;
	localparam int FRAME_W = 15;
	localparam int SUBF_W = 13;
	localparam int PROLOG_W = 6;
	localparam int CODE_W = 2;

	// byte offsets of the register map
	localparam logic [ADDR_W-1:0] OFS_FRAME = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_SUBF = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_PROLOG = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_MODE = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_HALT = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_FAULTS = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_PROGRESS = 8'h18;

	// mode register fields
	localparam int MODE_SHARED_BIT = 0;
	localparam int MODE_CODE_LSB = 1;
	// halt control register fields
	localparam int HALT_IGNORE_BIT = 0;
	localparam int HALT_SEL_BIT = 1;

	// input_check_faults fields
	localparam int FLT_ANY_BIT = 0;
	localparam int FLT_FRAME_BIT = 1;
	localparam int FLT_PROLOG_BIT = 2;
	localparam int FLT_SUBF_BIT = 4;

	// decoder_progress fields
	localparam int ST_MAP_BIT = 1;
	localparam int ST_FAULT_BIT = 2;
	localparam int ST_WAIT_LSB = 3;
	localparam int ST_HALTED_BIT = 10;
	localparam int ST_HALF_BIT = 11;
	localparam int ST_SUBST_LSB = 12;
	localparam int ST_ITER_LSB = 16;
	localparam int ST_TOP_LSB = 24;

	// limits on programmed lengths and on the active map state range
	localparam logic [SUBF_W-1:0] SUBF_MAX = 13'h13fa;
	localparam logic [PROLOG_W-1:0] PROLOG_MIN = 6'h04;
	localparam logic [PROLOG_W-1:0] PROLOG_MAX = 6'h30;
	localparam logic [FRAME_W-1:0] FULL_FRAME_MIN = 15'h0028;
	localparam logic [FRAME_W-1:0] FULL_FRAME_MAX = 15'h50fa;
	localparam logic [FRAME_W-1:0] SHR_FRAME_MIN12 = 15'h0100;
	localparam logic [FRAME_W-1:0] SHR_FRAME_MIN3 = 15'h0080;
	localparam logic [FRAME_W-1:0] SHR_FRAME_MAX = 15'h5000;
	localparam int SHR_ALIGN_BITS = 8;
	localparam logic [3:0] MAP_IDLE = 4'h0;
	localparam logic [3:0] MAP_LAST = 4'h8;

	// reset values of the writable registers
	localparam logic [FRAME_W-1:0] RST_FRAME = 15'h0028;
	localparam logic [SUBF_W-1:0] RST_SUBF = 13'h0000;
	localparam logic [PROLOG_W-1:0] RST_PROLOG = 6'h04;
	localparam logic [CODE_W-1:0] RST_CODE = 2'h1;
	localparam logic [1:0] RST_HALT = 2'h0;
endpackage
`default_nettype wire

// [rtl/tdes_range_chk.sv]
// flags a value lying outside an inclusive range.
// assumes both bounds are static or slow-changing; purely combinational.
`default_nettype none
module tdes_range_chk #(
	parameter int W = 8
) (
	input  wire logic [W-1:0] value,
	input  wire logic [W-1:0] lo,
	input  wire logic [W-1:0] hi,
	output logic              outside
);
	assign outside = (value < lo) || (value > hi);
endmodule
`default_nettype wire

// [rtl/tdes_regs.sv]
// error check and progress register bank of the turbo decoder.
// assumes core status inputs come from logic on pclk; cpu_halt_req is an
// asynchronous pin and is synchronised here.
`default_nettype none
module tdes_regs
	import tdes_pkg::*;
(
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [ADDR_W-1:0]   paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic [3:0]          top_state,
	input  wire logic [4:0]          active_iter,
	input  wire logic [3:0]          active_substate,
	input  wire logic                active_half,
	input  wire logic                halt_point_reached,
	input  wire logic                out_param_read_wait,
	input  wire logic                hard_decision_read_wait,
	input  wire logic                extrinsic0_read_wait,
	input  wire logic                apriori_write_wait,
	input  wire logic                sys_parity_write_wait,
	input  wire logic                interleaver_load_wait,
	input  wire logic                ctrl_word_load_wait,
	input  wire logic [3:0]          map_state,
	input  wire logic                cpu_halt_req,
	output logic                     decoder_halt,
	output logic                     input_fault,
	output logic      [FRAME_W-1:0]  frame_len,
	output logic      [SUBF_W-1:0]   subframe_len,
	output logic      [PROLOG_W-1:0] prolog_len,
	output logic                     shared_decode_mode,
	output logic      [CODE_W-1:0]   block_code_type
);
	logic              halt_ignore_r;
	logic              halt_sel_r;
	logic              halt_req_s;
	logic              debug_halted_r;
	logic [4:0]        fault_r;
	logic [6:0]        wait_r;
	logic [3:0]        top_r;
	logic [4:0]        iter_r;
	logic [3:0]        subst_r;
	logic              half_r;
	logic              map_active_r;
	logic              setup;
	logic              wr_en;
	logic              full_decode_mode;
	logic              subf_bad;
	logic              prolog_bad;
	logic              full_bad;
	logic              shr12_out;
	logic              shr3_out;
	logic              shr_unaligned;
	logic              frame_bad;
	logic              any_bad;
	logic [31:0]       faults_word;
	logic [31:0]       progress_word;
	logic [31:0]       rdata_nxt;
	logic              err_nxt;

	assign setup = psel && !penable;
	assign wr_en = psel && penable && pready && pwrite;
	assign full_decode_mode = !shared_decode_mode;

	// ---------------- apb slave ----------------
	// zero wait states: pready rises for the access phase of every transfer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= setup;
		end
	end

	always_comb begin
		rdata_nxt = 32'h0000_0000;
		err_nxt = 1'b0;
		unique case (paddr)
			OFS_FRAME: rdata_nxt = 32'(frame_len);
			OFS_SUBF: rdata_nxt = 32'(subframe_len);
			OFS_PROLOG: rdata_nxt = 32'(prolog_len);
			OFS_MODE: rdata_nxt = 32'({block_code_type, shared_decode_mode});
			OFS_HALT: rdata_nxt = 32'({halt_sel_r, halt_ignore_r});
			OFS_FAULTS: rdata_nxt = faults_word;
			OFS_PROGRESS: rdata_nxt = progress_word;
			default: err_nxt = 1'b1;
		endcase
	end

	// read data is captured at the setup edge and held through the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata <= pwrite ? 32'h0000_0000 : rdata_nxt;
			pslverr <= err_nxt;
		end else if (pready) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
	end

	// ---------------- writable configuration ----------------
	// fault and progress offsets are absent here, so writes to them do nothing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_len <= RST_FRAME;
			subframe_len <= RST_SUBF;
			prolog_len <= RST_PROLOG;
			shared_decode_mode <= 1'b0;
			block_code_type <= RST_CODE;
			{halt_sel_r, halt_ignore_r} <= RST_HALT;
		end else if (wr_en && !pslverr) begin
			unique case (paddr)
				OFS_FRAME: frame_len <= pwdata[FRAME_W-1:0];
				OFS_SUBF: subframe_len <= pwdata[SUBF_W-1:0];
				OFS_PROLOG: prolog_len <= pwdata[PROLOG_W-1:0];
				OFS_MODE: begin
					shared_decode_mode <= pwdata[MODE_SHARED_BIT];
					block_code_type <= pwdata[MODE_CODE_LSB +: CODE_W];
				end
				OFS_HALT: begin
					halt_ignore_r <= pwdata[HALT_IGNORE_BIT];
					halt_sel_r <= pwdata[HALT_SEL_BIT];
				end
				default: ;
			endcase
		end
	end

	// ---------------- input checks ----------------
	assign subf_bad = subframe_len > SUBF_MAX;

	tdes_range_chk #(.W(PROLOG_W)) u_prolog_chk (
		.value   (prolog_len),
		.lo      (PROLOG_MIN),
		.hi      (PROLOG_MAX),
		.outside (prolog_bad)
	);

	tdes_range_chk #(.W(FRAME_W)) u_full_chk (
		.value   (frame_len),
		.lo      (FULL_FRAME_MIN),
		.hi      (FULL_FRAME_MAX),
		.outside (full_bad)
	);

	tdes_range_chk #(.W(FRAME_W)) u_shr12_chk (
		.value   (frame_len),
		.lo      (SHR_FRAME_MIN12),
		.hi      (SHR_FRAME_MAX),
		.outside (shr12_out)
	);

	tdes_range_chk #(.W(FRAME_W)) u_shr3_chk (
		.value   (frame_len),
		.lo      (SHR_FRAME_MIN3),
		.hi      (SHR_FRAME_MAX),
		.outside (shr3_out)
	);

	assign shr_unaligned = |frame_len[SHR_ALIGN_BITS-1:0];

	// in shared mode block code type 0 has no defined length window, so it is always flagged
	always_comb begin
		frame_bad = 1'b1;
		if (full_decode_mode) begin
			frame_bad = full_bad;
		end else if (block_code_type == 2'h3) begin
			frame_bad = shr3_out;
		end else if (block_code_type != 2'h0) begin
			frame_bad = shr12_out || shr_unaligned;
		end
	end

	assign any_bad = subf_bad || prolog_bad || frame_bad;

	// one flop feeds both registers so the two fault flags never disagree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_r <= 5'h00;
		end else begin
			fault_r <= {subf_bad, 1'b0, prolog_bad, frame_bad, any_bad};
		end
	end

	assign input_fault = fault_r[FLT_ANY_BIT];
	assign faults_word = {27'h0, fault_r};

	// ---------------- debug halt ----------------
	tdes_sync2 u_halt_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (cpu_halt_req),
		.sync_out (halt_req_s)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			decoder_halt <= 1'b0;
			debug_halted_r <= 1'b0;
		end else begin
			decoder_halt <= halt_req_s && !halt_ignore_r;
			debug_halted_r <= decoder_halt && halt_point_reached;
		end
	end

	// ---------------- progress capture ----------------
	// inputs are sampled every cycle so each read shows live state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			top_r <= 4'h0;
			iter_r <= 5'h00;
			subst_r <= 4'h0;
			half_r <= 1'b0;
			wait_r <= 7'h00;
			map_active_r <= 1'b0;
		end else begin
			top_r <= top_state;
			iter_r <= active_iter;
			subst_r <= active_substate;
			half_r <= active_half;
			wait_r <= {out_param_read_wait, hard_decision_read_wait, extrinsic0_read_wait,
				apriori_write_wait, sys_parity_write_wait, interleaver_load_wait,
				ctrl_word_load_wait};
			map_active_r <= (map_state != MAP_IDLE) && (map_state <= MAP_LAST);
		end
	end

	// reserved halt fields read as zero in the select combinations that undefine them
	always_comb begin
		progress_word = 32'h0000_0000;
		progress_word[ST_TOP_LSB +: 4] = top_r;
		progress_word[ST_ITER_LSB +: 5] = iter_r;
		progress_word[ST_SUBST_LSB +: 4] = subst_r;
		progress_word[ST_HALF_BIT] = half_r && (halt_ignore_r || halt_sel_r);
		progress_word[ST_HALTED_BIT] = debug_halted_r && !(!halt_ignore_r && halt_sel_r);
		progress_word[ST_WAIT_LSB +: 7] = wait_r;
		progress_word[ST_FAULT_BIT] = fault_r[FLT_ANY_BIT];
		progress_word[ST_MAP_BIT] = map_active_r;
	end

	// ---------------- assertions ----------------
	property p_subf;
		@(posedge pclk) disable iff (!presetn)
		fault_r[FLT_SUBF_BIT] == ($past(subframe_len) > SUBF_MAX);
	endproperty
	a_subf: assert property (p_subf) else $error("subframe fault wrong");

	property p_prolog;
		@(posedge pclk) disable iff (!presetn)
		fault_r[FLT_PROLOG_BIT] == ($past(prolog_len) < PROLOG_MIN || $past(prolog_len) > PROLOG_MAX);
	endproperty
	a_prolog: assert property (p_prolog) else $error("prolog fault wrong");

	property p_full;
		@(posedge pclk) disable iff (!presetn)
		$past(full_decode_mode) |->
			fault_r[FLT_FRAME_BIT] == ($past(frame_len) < FULL_FRAME_MIN || $past(frame_len) > FULL_FRAME_MAX);
	endproperty
	a_full: assert property (p_full) else $error("full mode frame fault wrong");

	property p_shr12;
		@(posedge pclk) disable iff (!presetn)
		$past(shared_decode_mode) && ($past(block_code_type) inside {2'h1, 2'h2}) |->
			fault_r[FLT_FRAME_BIT] == ($past(frame_len) < SHR_FRAME_MIN12 || $past(frame_len) > SHR_FRAME_MAX
				|| $past(frame_len[7:0]) != 8'h00);
	endproperty
	a_shr12: assert property (p_shr12) else $error("shared type 1/2 frame fault wrong");

	property p_shr3;
		@(posedge pclk) disable iff (!presetn)
		$past(shared_decode_mode) && $past(block_code_type) == 2'h3 |->
			fault_r[FLT_FRAME_BIT] == ($past(frame_len) < SHR_FRAME_MIN3 || $past(frame_len) > SHR_FRAME_MAX);
	endproperty
	a_shr3: assert property (p_shr3) else $error("shared type 3 frame fault wrong");

	property p_any;
		@(posedge pclk) disable iff (!presetn)
		fault_r[FLT_ANY_BIT] == (|fault_r[4:1]);
	endproperty
	a_any: assert property (p_any) else $error("summary fault wrong");

	property p_fault_read;
		@(posedge pclk) disable iff (!presetn)
		psel && penable && pready && !pwrite && $past(paddr) == OFS_FAULTS |->
			prdata[31:5] == 27'h0 && prdata[3] == 1'b0;
	endproperty
	a_fault_read: assert property (p_fault_read) else $error("reserved fault bits not zero");

	property p_top_read;
		@(posedge pclk) disable iff (!presetn)
		psel && penable && pready && !pwrite && paddr == OFS_PROGRESS |->
			prdata[27:24] == $past(top_state, 2) && prdata[20:16] == $past(active_iter, 2)
			&& prdata[31:28] == 4'h0 && prdata[0] == 1'b0;
	endproperty
	a_top_read: assert property (p_top_read) else $error("progress read mismatch");

	// wait flags pass through one capture flop and the read data flop
	property p_wait_read;
		@(posedge pclk) disable iff (!presetn)
		psel && penable && pready && !pwrite && paddr == OFS_PROGRESS |->
			prdata[9:3] == $past({out_param_read_wait, hard_decision_read_wait, extrinsic0_read_wait,
				apriori_write_wait, sys_parity_write_wait, interleaver_load_wait, ctrl_word_load_wait}, 2);
	endproperty
	a_wait_read: assert property (p_wait_read) else $error("wait flags read mismatch");

	property p_mirror;
		@(posedge pclk) disable iff (!presetn)
		progress_word[ST_FAULT_BIT] == faults_word[FLT_ANY_BIT];
	endproperty
	a_mirror: assert property (p_mirror) else $error("fault mirror mismatch");

	property p_ignore;
		@(posedge pclk) disable iff (!presetn)
		halt_ignore_r && $past(halt_ignore_r) |-> !decoder_halt ##1 !debug_halted_r;
	endproperty
	a_ignore: assert property (p_ignore) else $error("halt taken while ignored");

	property p_halted;
		@(posedge pclk) disable iff (!presetn)
		$rose(cpu_halt_req) && !halt_ignore_r ##1 (cpu_halt_req && !halt_ignore_r)[*3] ##1 halt_point_reached
			|=> debug_halted_r;
	endproperty
	a_halted: assert property (p_halted) else $error("debug halt not reported");

	property p_map;
		@(posedge pclk) disable iff (!presetn)
		map_state == MAP_IDLE |=> !map_active_r;
	endproperty
	a_map: assert property (p_map) else $error("engine busy while idle");

	c_fault: cover property (@(posedge pclk) disable iff (!presetn) $rose(input_fault));
	c_halt: cover property (@(posedge pclk) disable iff (!presetn) $rose(debug_halted_r));
	c_read: cover property (@(posedge pclk) disable iff (!presetn)
		psel && penable && pready && paddr == OFS_PROGRESS);
	c_shared_bad: cover property (@(posedge pclk) disable iff (!presetn) shared_decode_mode && fault_r[FLT_FRAME_BIT]);
	c_ignored: cover property (@(posedge pclk) disable iff (!presetn) halt_ignore_r && halt_req_s);
endmodule
`default_nettype wire

// [rtl/tdes_sync2.sv]
// two-flop synchroniser for a level arriving from another domain.
// assumes the level stays stable for more than two clock periods.
`default_nettype none
module tdes_sync2 (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic async_in,
	output logic      sync_out
);
	logic meta_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule
`default_nettype wire
